/* rtl/adc_clock_map.vh */
// Behaviour
// - system clock is master clock pin edges divided by the 3-bit master divider
// - serial clock may become the system clock, only in synchronous slave mode
// - modulator clock is system clock divided by the 3-bit system clock divider
// - source select bit picks divided clock pin or undivided serial clock as system clock source
// - synchronous master mode drives the serial clock out, toggled on every system clock tick
// - results come at modulator clock divided by one of 16 oversampling ratios
// - one oversampling ratio applies to every channel, one common data rate
`ifndef ADC_CLOCK_MAP_VH
`define ADC_CLOCK_MAP_VH

// ==================================================
// register map
`define ADDR_W 12
`define REG_CLOCK_CONFIG_ONE 12'h000
`define REG_CLOCK_CONFIG_TWO 12'h004
`define REG_CONTROL 12'h008
`define REG_STATUS 12'h00C

// ==================================================
// field positions
`define MASTER_DIV_LSB 0
`define MASTER_DIV_MSB 2
`define CLOCK_SOURCE_BIT 5
`define OSR_LSB 0
`define OSR_MSB 3
`define SYS_DIV_LSB 5
`define SYS_DIV_MSB 7
`define CHANNEL_POWER_BIT 0
`define STAT_MODE_LSB 0
`define STAT_MODE_MSB 1
`define STAT_SCLK_ROUTED_BIT 2
`define STAT_SETTLED_BIT 3
`define STAT_RUNNING_BIT 4

// ==================================================
// reset values
`define MASTER_DIV_RESET 3'h2
`define SYS_DIV_RESET 3'h2
`define OSR_RESET 4'h0
`define CLOCK_SOURCE_RESET 1'b0

// ==================================================
// interface modes
`define MODE_ASYNC_INTERRUPT 2'h0
`define MODE_SYNC_MASTER 2'h1
`define MODE_SYNC_SLAVE 2'h2

// ==================================================
// divider ratios
`define RATIO_W 13
`define DIV_RATIO_MIN 13'h0002

// ==================================================
// oversampling ratios, code 0 to 15
`define OSR_C0 13'h1000
`define OSR_C1 13'h0800
`define OSR_C2 13'h0400
`define OSR_C3 13'h0320
`define OSR_C4 13'h0300
`define OSR_C5 13'h0200
`define OSR_C6 13'h0190
`define OSR_C7 13'h0180
`define OSR_C8 13'h0100
`define OSR_C9 13'h00C8
`define OSR_C10 13'h00C0
`define OSR_C11 13'h0080
`define OSR_C12 13'h0060
`define OSR_C13 13'h0040
`define OSR_C14 13'h0030
`define OSR_C15 13'h0020

// ==================================================
// timing
`define CORE_CLK_KHZ 50000
`define STRAP_FILL 2'h2
`define XTAL_START_US 5000

`endif

/* rtl/pin_sync.v */
`timescale 1ns/10ps
// ==================================================
// two-flop synchroniser with rising edge pulse
module pin_sync (
	input wire i_clk,
	input wire i_rst,
	input wire i_async,
	output wire o_level,
	output reg o_rise
);
	reg meta_reg;
	reg sync_reg;
	reg prev_reg;

	always @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
			o_rise <= 1'b0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			o_rise <= sync_reg & ~prev_reg;
		end
	end

	assign o_level = sync_reg;
endmodule // pin_sync

/* rtl/tick_divider.v */
`timescale 1ns/10ps
// ==================================================
// divides a tick enable by a ratio
module tick_divider #(
	parameter W = 13
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_run,
	input wire i_tick,
	input wire [W-1:0] i_ratio,
	output reg o_tick
);
	reg [W-1:0] count_reg;
	wire [W-1:0] last_count;

	assign last_count = i_ratio - {{(W-1){1'b0}}, 1'b1};

	always @(posedge i_clk) begin
		if (i_rst) begin
			count_reg <= {W{1'b0}};
			o_tick <= 1'b0;
		end else if (!i_run) begin
			count_reg <= {W{1'b0}};
			o_tick <= 1'b0;
		end else if (i_tick) begin
			if (count_reg >= last_count) begin
				count_reg <= {W{1'b0}};
				o_tick <= 1'b1;
			end else begin
				count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
				o_tick <= 1'b0;
			end
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule // tick_divider

/* rtl/adc_clock_generation.v */
`timescale 1ns/10ps
`include "adc_clock_map.vh"
// ==================================================
// converter clock generation with apb registers
module adc_clock_generation #(
	parameter XTAL_START_CYCLES = `XTAL_START_US * (`CORE_CLK_KHZ / 1000)
) (
	input wire I_CORE_CLK,
	input wire I_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [`ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire [3:0] I_PSTRB,
	output reg O_PREADY,
	output reg [31:0] O_PRDATA,
	output reg O_PSLVERR,
	input wire I_CRYSTAL_OR_CLOCK_PIN,
	input wire I_SCLK_IN,
	input wire [1:0] I_INTERFACE_MODE_PIN,
	output reg O_SCLK_OUT,
	output reg O_SCLK_OE,
	output reg O_INTERNAL_SYSTEM_CLOCK,
	output reg O_MODULATOR_CLOCK,
	output reg O_CONVERSION_READY_SIGNAL,
	output reg O_CHANNEL_POWER,
	output reg O_CLOCK_SETTLED
);
	// ==================================================
	// declarations
	wire master_rise;
	wire sclk_rise;
	wire mode_bit0;
	wire mode_bit1;
	wire master_level;
	wire sclk_level;
	wire system_tick_div;
	wire modulator_tick;
	wire ready_tick;
	wire sclk_routed;
	wire system_tick;
	wire apb_access;
	wire apb_write;
	wire apb_read;
	wire addr_hit;
	wire [`RATIO_W-1:0] master_ratio;
	wire [`RATIO_W-1:0] sys_ratio;
	wire [`RATIO_W-1:0] osr_ratio;
	reg [2:0] master_div_reg;
	reg [2:0] master_div_next;
	reg clock_source_reg;
	reg clock_source_next;
	reg [2:0] sys_div_reg;
	reg [2:0] sys_div_next;
	reg [3:0] osr_reg;
	reg [3:0] osr_next;
	reg power_reg;
	reg power_next;
	reg [1:0] mode_reg;
	reg strap_taken_reg;
	reg [1:0] strap_wait_reg;
	reg [31:0] settle_count_reg;
	reg settled_reg;
	reg [31:0] read_value;

	// ==================================================
	// pin synchronisers
	pin_sync u_master_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_async(I_CRYSTAL_OR_CLOCK_PIN),
		.o_level(master_level),
		.o_rise(master_rise)
	);

	pin_sync u_sclk_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_async(I_SCLK_IN),
		.o_level(sclk_level),
		.o_rise(sclk_rise)
	);

	pin_sync u_mode0_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_async(I_INTERFACE_MODE_PIN[0]),
		.o_level(mode_bit0),
		.o_rise()
	);

	pin_sync u_mode1_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_async(I_INTERFACE_MODE_PIN[1]),
		.o_level(mode_bit1),
		.o_rise()
	);

	// ==================================================
	// interface mode strap, caught once after reset
	// waits for the synchronisers to refill before sampling
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			mode_reg <= `MODE_ASYNC_INTERRUPT;
			strap_taken_reg <= 1'b0;
			strap_wait_reg <= 2'h0;
		end else if (strap_wait_reg != `STRAP_FILL) begin
			strap_wait_reg <= strap_wait_reg + 2'h1;
		end else if (!strap_taken_reg && !power_reg) begin
			mode_reg <= {mode_bit1, mode_bit0};
			strap_taken_reg <= 1'b1;
		end
	end

	// ==================================================
	// ratio lookup
	function [`RATIO_W-1:0] div_ratio;
		input [2:0] field;
		begin
			if (field == 3'h0) begin
				div_ratio = `DIV_RATIO_MIN;
			end else begin
				div_ratio = {{(`RATIO_W-4){1'b0}}, field, 1'b0};
			end
		end
	endfunction

	function [`RATIO_W-1:0] osr_lookup;
		input [3:0] code;
		begin
			case (code)
				4'h0: osr_lookup = `OSR_C0;
				4'h1: osr_lookup = `OSR_C1;
				4'h2: osr_lookup = `OSR_C2;
				4'h3: osr_lookup = `OSR_C3;
				4'h4: osr_lookup = `OSR_C4;
				4'h5: osr_lookup = `OSR_C5;
				4'h6: osr_lookup = `OSR_C6;
				4'h7: osr_lookup = `OSR_C7;
				4'h8: osr_lookup = `OSR_C8;
				4'h9: osr_lookup = `OSR_C9;
				4'hA: osr_lookup = `OSR_C10;
				4'hB: osr_lookup = `OSR_C11;
				4'hC: osr_lookup = `OSR_C12;
				4'hD: osr_lookup = `OSR_C13;
				4'hE: osr_lookup = `OSR_C14;
				default: osr_lookup = `OSR_C15;
			endcase
		end
	endfunction

	assign master_ratio = div_ratio(master_div_reg);
	assign sys_ratio = div_ratio(sys_div_reg);
	assign osr_ratio = osr_lookup(osr_reg);

	// ==================================================
	// clock source selection
	// serial clock only honoured in slave mode; pin used otherwise
	assign sclk_routed = clock_source_reg && (mode_reg == `MODE_SYNC_SLAVE);

	tick_divider #(
		.W(`RATIO_W)
	) u_master_div (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_run(~sclk_routed),
		.i_tick(master_rise),
		.i_ratio(master_ratio),
		.o_tick(system_tick_div)
	);

	assign system_tick = sclk_routed ? sclk_rise : system_tick_div;

	// ==================================================
	// modulator clock and data rate
	tick_divider #(
		.W(`RATIO_W)
	) u_sys_div (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_run(power_reg),
		.i_tick(system_tick),
		.i_ratio(sys_ratio),
		.o_tick(modulator_tick)
	);

	// single ratio shared by every channel
	tick_divider #(
		.W(`RATIO_W)
	) u_osr_div (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_run(power_reg),
		.i_tick(modulator_tick),
		.i_ratio(osr_ratio),
		.o_tick(ready_tick)
	);

	// ==================================================
	// crystal start-up wait
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			settle_count_reg <= 32'h0000_0000;
			settled_reg <= 1'b0;
		end else if (sclk_routed) begin
			settle_count_reg <= 32'h0000_0000;
			settled_reg <= 1'b1;
		end else if (settle_count_reg >= XTAL_START_CYCLES - 1) begin
			settled_reg <= 1'b1;
		end else begin
			settle_count_reg <= settle_count_reg + 32'h0000_0001;
			settled_reg <= 1'b0;
		end
	end

	// ==================================================
	// apb slave
	assign apb_access = I_PSEL & I_PENABLE & O_PREADY;
	assign apb_write = apb_access & I_PWRITE;
	assign apb_read = apb_access & ~I_PWRITE;
	assign addr_hit = (I_PADDR == `REG_CLOCK_CONFIG_ONE) || (I_PADDR == `REG_CLOCK_CONFIG_TWO) ||
		(I_PADDR == `REG_CONTROL) || (I_PADDR == `REG_STATUS);

	always @* begin
		master_div_next = master_div_reg;
		clock_source_next = clock_source_reg;
		sys_div_next = sys_div_reg;
		osr_next = osr_reg;
		power_next = power_reg;
		if (apb_write && I_PSTRB[0]) begin
			case (I_PADDR)
				`REG_CLOCK_CONFIG_ONE: begin
					master_div_next = I_PWDATA[`MASTER_DIV_MSB:`MASTER_DIV_LSB];
					// source locked while channels are powered
					if (!power_reg) begin
						clock_source_next = I_PWDATA[`CLOCK_SOURCE_BIT];
					end
				end
				`REG_CLOCK_CONFIG_TWO: begin
					sys_div_next = I_PWDATA[`SYS_DIV_MSB:`SYS_DIV_LSB];
					osr_next = I_PWDATA[`OSR_MSB:`OSR_LSB];
				end
				`REG_CONTROL: begin
					power_next = I_PWDATA[`CHANNEL_POWER_BIT];
				end
				default: begin
					power_next = power_reg;
				end
			endcase
		end
	end

	always @* begin
		read_value = 32'h0000_0000;
		case (I_PADDR)
			`REG_CLOCK_CONFIG_ONE: begin
				read_value[`MASTER_DIV_MSB:`MASTER_DIV_LSB] = master_div_reg;
				read_value[`CLOCK_SOURCE_BIT] = clock_source_reg;
			end
			`REG_CLOCK_CONFIG_TWO: begin
				read_value[`SYS_DIV_MSB:`SYS_DIV_LSB] = sys_div_reg;
				read_value[`OSR_MSB:`OSR_LSB] = osr_reg;
			end
			`REG_CONTROL: begin
				read_value[`CHANNEL_POWER_BIT] = power_reg;
			end
			`REG_STATUS: begin
				read_value[`STAT_MODE_MSB:`STAT_MODE_LSB] = mode_reg;
				read_value[`STAT_SCLK_ROUTED_BIT] = sclk_routed;
				read_value[`STAT_SETTLED_BIT] = settled_reg;
				read_value[`STAT_RUNNING_BIT] = power_reg;
			end
			default: begin
				read_value = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			master_div_reg <= `MASTER_DIV_RESET;
			clock_source_reg <= `CLOCK_SOURCE_RESET;
			sys_div_reg <= `SYS_DIV_RESET;
			osr_reg <= `OSR_RESET;
			power_reg <= 1'b0;
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else begin
			master_div_reg <= master_div_next;
			clock_source_reg <= clock_source_next;
			sys_div_reg <= sys_div_next;
			osr_reg <= osr_next;
			power_reg <= power_next;
			O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
			if (I_PSEL && I_PENABLE && !O_PREADY) begin
				O_PRDATA <= I_PWRITE ? 32'h0000_0000 : read_value;
				O_PSLVERR <= ~addr_hit;
			end else begin
				O_PRDATA <= 32'h0000_0000;
				O_PSLVERR <= 1'b0;
			end
		end
	end

	// ==================================================
	// clock outputs
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			O_SCLK_OUT <= 1'b0;
			O_SCLK_OE <= 1'b0;
			O_INTERNAL_SYSTEM_CLOCK <= 1'b0;
			O_MODULATOR_CLOCK <= 1'b0;
			O_CONVERSION_READY_SIGNAL <= 1'b0;
			O_CHANNEL_POWER <= 1'b0;
			O_CLOCK_SETTLED <= 1'b0;
		end else begin
			O_INTERNAL_SYSTEM_CLOCK <= system_tick;
			O_MODULATOR_CLOCK <= modulator_tick;
			O_CONVERSION_READY_SIGNAL <= ready_tick;
			O_CHANNEL_POWER <= power_reg;
			O_CLOCK_SETTLED <= settled_reg;
			if (mode_reg == `MODE_SYNC_MASTER) begin
				O_SCLK_OE <= 1'b1;
				if (system_tick) begin
					O_SCLK_OUT <= ~O_SCLK_OUT;
				end
			end else begin
				O_SCLK_OE <= 1'b0;
				O_SCLK_OUT <= 1'b0;
			end
		end
	end
endmodule // adc_clock_generation

/* bench/adc_clock_check_sva.sv */
`timescale 1ns/10ps
// ==========
// clock path and bus checks
module adc_clock_check (
	input logic I_CORE_CLK,
	input logic I_RST,
	input logic I_PSEL,
	input logic I_PENABLE,
	input logic O_PREADY,
	input logic [31:0] O_PRDATA,
	input logic O_PSLVERR,
	input logic O_SCLK_OUT,
	input logic O_SCLK_OE,
	input logic O_INTERNAL_SYSTEM_CLOCK,
	input logic O_MODULATOR_CLOCK,
	input logic O_CONVERSION_READY_SIGNAL,
	input logic O_CHANNEL_POWER
);
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RST);
	sclk_idle_low_a: assert property (!O_SCLK_OE |-> !O_SCLK_OUT)
		else $error("serial clock out moves while undriven");
	sclk_tick_a: assert property ($changed(O_SCLK_OUT) && O_SCLK_OE
		|-> O_INTERNAL_SYSTEM_CLOCK or $past(O_INTERNAL_SYSTEM_CLOCK))
		else $error("serial clock out not on system tick");
	mod_power_a: assert property (O_MODULATOR_CLOCK
		|-> O_CHANNEL_POWER || $past(O_CHANNEL_POWER) || $past(O_CHANNEL_POWER, 2))
		else $error("modulator tick while unpowered");
	mod_after_sys_a: assert property (O_MODULATOR_CLOCK |-> $past(O_INTERNAL_SYSTEM_CLOCK))
		else $error("modulator tick without system tick");
	mod_spacing_a: assert property (O_MODULATOR_CLOCK |=> !O_MODULATOR_CLOCK)
		else $error("modulator ticks adjacent");
	ready_after_mod_a: assert property (O_CONVERSION_READY_SIGNAL |-> $past(O_MODULATOR_CLOCK))
		else $error("result without modulator tick");
	ready_spacing_a: assert property (O_CONVERSION_READY_SIGNAL
		|=> !O_CONVERSION_READY_SIGNAL [*8])
		else $error("results too close");
	apb_answer_a: assert property (I_PSEL && $rose(I_PENABLE) |=> O_PREADY)
		else $error("bus answer late");
	apb_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0000_0000 && !O_PSLVERR)
		else $error("bus data outside answer");
	cover property (O_CONVERSION_READY_SIGNAL);
	cover property (O_SCLK_OE && O_SCLK_OUT);
	cover property (O_PSLVERR);
endmodule // adc_clock_check

bind adc_clock_generation adc_clock_check chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA),
	.O_PSLVERR(O_PSLVERR), .O_SCLK_OUT(O_SCLK_OUT), .O_SCLK_OE(O_SCLK_OE),
	.O_INTERNAL_SYSTEM_CLOCK(O_INTERNAL_SYSTEM_CLOCK), .O_MODULATOR_CLOCK(O_MODULATOR_CLOCK),
	.O_CONVERSION_READY_SIGNAL(O_CONVERSION_READY_SIGNAL), .O_CHANNEL_POWER(O_CHANNEL_POWER));

/* bench/clock_source_model.sv */
`timescale 1ns/10ps
// ==========
// master clock pin and free-running serial clock
module clock_source_model #(
	parameter int PIN_HALF = 4,
	parameter int SCLK_HALF = 6
) (
	input wire logic i_clk,
	output logic o_pin,
	output logic o_sclk
);
	int pin_cnt = 0;
	int sclk_cnt = 0;
	initial begin
		o_pin = 1'b0;
		o_sclk = 1'b0;
	end
	// direct clock on the pin
	always @(posedge i_clk) begin
		pin_cnt <= (pin_cnt == PIN_HALF - 1) ? 0 : pin_cnt + 1;
		if (pin_cnt == PIN_HALF - 1) o_pin <= ~o_pin;
	end
	always @(posedge i_clk) begin
		sclk_cnt <= (sclk_cnt == SCLK_HALF - 1) ? 0 : sclk_cnt + 1;
		if (sclk_cnt == SCLK_HALF - 1) o_sclk <= ~o_sclk;
	end
endmodule // clock_source_model

/* bench/adc_clock_generation_bench.sv */
`timescale 1ns/10ps
`include "adc_clock_map.vh"
// ==========
// clock generation bench
module adc_clock_generation_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hF;
	logic [1:0] strap = 2'h0;
	logic pready, pslverr, sclk_out, sclk_oe, sys_ck, mod_ck, rdy, pwr, settled, pin, m_sclk;
	logic [31:0] prdata;
	logic [31:0] r;
	logic e;
	wire sclk_wire = sclk_oe ? sclk_out : m_sclk;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	int g;
	typedef struct {int m, src, md, sd, osr, oe, rt, gs, gm, gr;} row_t;
	// mode, source, dividers, ratio code, then expected results
	row_t rows[6] = '{'{0,1,1,1,15,0,0,16,32,1024}, '{1,0,0,2,15,1,0,16,64,2048},
		'{2,1,2,0,14,0,1,12,24,1152}, '{3,1,7,1,15,0,0,112,224,7168},
		'{2,0,1,1,13,0,0,16,32,2048}, '{2,1,1,1,12,0,1,12,24,2304}};
	always #10 clk = ~clk;
	clock_source_model src_u (.i_clk(clk), .o_pin(pin), .o_sclk(m_sclk));
	adc_clock_generation #(.XTAL_START_CYCLES(20)) dut_u (.I_CORE_CLK(clk), .I_RST(rst),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready), .O_PRDATA(prdata),
		.O_PSLVERR(pslverr), .I_CRYSTAL_OR_CLOCK_PIN(pin), .I_SCLK_IN(sclk_wire),
		.I_INTERFACE_MODE_PIN(strap), .O_SCLK_OUT(sclk_out), .O_SCLK_OE(sclk_oe),
		.O_INTERNAL_SYSTEM_CLOCK(sys_ck), .O_MODULATOR_CLOCK(mod_ck),
		.O_CONVERSION_READY_SIGNAL(rdy), .O_CHANNEL_POWER(pwr), .O_CLOCK_SETTLED(settled));
	task complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_fail++;
			complete_run;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset(input logic [1:0] m);
		@(posedge clk);
		strap <= m;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
	endtask
	function automatic logic pk(int s);
		return s == 0 ? sys_ck : s == 1 ? mod_ck : rdy;
	endfunction
	task automatic gap(input int s);
		@(posedge clk);
		while (pk(s) !== 1'b1) @(posedge clk);
		@(posedge clk);
		g = 1;
		while (pk(s) !== 1'b1) begin
			@(posedge clk);
			g++;
		end
	endtask
	task automatic run_row(input row_t w);
		do_reset(2'(w.m));
		chk(settled, 32'h0000_0000);
		apb(1, `REG_CLOCK_CONFIG_ONE, 32'(w.src * 32 + w.md));
		apb(1, `REG_CLOCK_CONFIG_TWO, 32'(w.sd * 32 + w.osr));
		apb(1, `REG_CONTROL, 32'h0000_0001);
		apb(0, `REG_STATUS, 32'h0000_0000);
		chk(r[2], 32'(w.rt));
		chk(sclk_oe, 32'(w.oe));
		gap(0);
		chk(g, w.gs);
		e = sclk_out;
		@(posedge clk);
		while (sys_ck !== 1'b1) @(posedge clk);
		chk(sclk_out ^ e, 32'(w.oe));
		gap(1);
		chk(g, w.gm);
		gap(2);
		chk(g, w.gr);
		chk(settled, 32'h0000_0001);
	endtask
	initial begin
		for (int i = 0; i < 6; i++) begin
			run_row(rows[i]);
		end
		apb(0, 12'h010, 32'h0000_0000);
		chk(e, 32'h0000_0001);
		chk(r, 32'h0000_0000);
		apb(1, `REG_CLOCK_CONFIG_ONE, 32'h0000_0001);
		apb(0, `REG_CLOCK_CONFIG_ONE, 32'h0000_0000);
		chk(r, 32'h0000_0021);
		pstrb <= 4'h0;
		apb(1, `REG_CLOCK_CONFIG_TWO, 32'h0000_00FF);
		pstrb <= 4'hF;
		apb(0, `REG_CLOCK_CONFIG_TWO, 32'h0000_0000);
		chk(r, 32'h0000_002C);
		do_reset(2'h0);
		apb(0, `REG_CLOCK_CONFIG_ONE, 32'h0000_0000);
		chk(r, 32'h0000_0002);
		apb(0, `REG_CLOCK_CONFIG_TWO, 32'h0000_0000);
		chk(r, 32'h0000_0040);
		apb(0, `REG_CONTROL, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk(pwr, 32'h0000_0000);
		complete_run;
	end
endmodule // adc_clock_generation_bench
